// ---- sdc_map.vh ----
// constants for the sdram command-acceptance block
`ifndef SDC_MAP_VH
`define SDC_MAP_VH

// command codes {ras_n,cas_n,we_n} with chip select low
`define SDC_CODE_NOP      3'h7
`define SDC_CODE_BST      3'h6
`define SDC_CODE_READ     3'h5
`define SDC_CODE_WRITE    3'h4
`define SDC_CODE_ACT      3'h3
`define SDC_CODE_PRE      3'h2
`define SDC_CODE_REF      3'h1
`define SDC_CODE_MODE     3'h0

// decoded command index
`define SDC_CMD_DESELECT_CMD      4'h0
`define SDC_CMD_NOP       4'h1
`define SDC_CMD_BST       4'h2
`define SDC_CMD_READ      4'h3
`define SDC_CMD_WRITE     4'h4
`define SDC_CMD_ACT       4'h5
`define SDC_CMD_PRE       4'h6
`define SDC_CMD_REF       4'h7
`define SDC_CMD_MODE      4'h8

// address field positions
`define SDC_BANK_BIT      11
`define SDC_AP_BIT        10
`define SDC_BL_LSB        0
`define SDC_BL_FULLPAGE   3'h7
`define SDC_MODE_RESET    12'h000

// clock period and timing intervals in ns
`define SDC_CLK_NS        40
`define SDC_T_DAL_NS      80
`define SDC_T_RP_NS       60
`define SDC_T_MCD_NS      40
`define SDC_T_RCD_NS      60
`define SDC_T_RRD_NS      40
`define SDC_T_RAS_NS      120
`define SDC_T_RC_NS       180
`define SDC_T_WR_NS       40

// least times rounded up, at least one cycle
`define SDC_CYC(ns)       ((((ns) + `SDC_CLK_NS - 1) / `SDC_CLK_NS) < 1 ? 1 : \
                           (((ns) + `SDC_CLK_NS - 1) / `SDC_CLK_NS))

`endif

// ---- sdc_bank.v ----
// one bank's state and its interval counter
`timescale 1ns/1ns
`include "sdc_map.vh"

module sdc_bank #(
    parameter CNT_W = 8
) (
    // clock and reset
    input  wire             i_clock,
    input  wire             i_rstn,
    // commands aimed at this bank
    input  wire             i_act,
    input  wire             i_rd,
    input  wire             i_wr,
    input  wire             i_ap,
    input  wire             i_pre,
    input  wire             i_bst,
    input  wire [2:0]       i_burst_len,
    input  wire             i_ena,
    // timing loads
    input  wire [CNT_W-1:0] i_rcd_cyc,
    input  wire [CNT_W-1:0] i_rp_cyc,
    input  wire [CNT_W-1:0] i_dal_cyc,
    input  wire [CNT_W-1:0] i_ras_cyc,
    input  wire [CNT_W-1:0] i_wr_cyc,
    // state view
    output wire [2:0]       o_state,
    output wire             o_ras_met,
    output wire             o_row_ready
);

    //****************************************************************
    // bank states
    //****************************************************************
    localparam ST_IDLE  = 3'h0;
    localparam ST_OPEN  = 3'h1;
    localparam ST_ACTV  = 3'h2;
    localparam ST_BURST = 3'h3;
    localparam ST_WRAP  = 3'h4;
    localparam ST_PRE   = 3'h5;

    reg [2:0]       state_ff;
    reg [2:0]       nxt_state;
    reg [CNT_W-1:0] cnt_ff;
    reg [CNT_W-1:0] nxt_cnt;
    reg [CNT_W-1:0] ras_ff;
    reg             ap_ff;
    reg             wr_ff;
    reg [8:0]       beat_ff;
    reg [8:0]       nxt_beat;

    wire            cnt_done = (cnt_ff == {CNT_W{1'b0}});
    wire [8:0]      burst_beats = (i_burst_len == `SDC_BL_FULLPAGE) ? 9'h100 :
                                  (9'h001 << i_burst_len[1:0]);

    always @* begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_done ? cnt_ff : cnt_ff - {{(CNT_W-1){1'b0}}, 1'b1};
        nxt_beat  = (beat_ff != 9'h000) ? beat_ff - 9'h001 : beat_ff;
        case (state_ff)
            ST_IDLE: begin
                if (i_act) begin
                    nxt_state = ST_OPEN;
                    nxt_cnt   = i_rcd_cyc - {{(CNT_W-1){1'b0}}, 1'b1};
                end
            end
            ST_OPEN: begin
                if (cnt_done)
                    nxt_state = ST_ACTV;
            end
            ST_ACTV: begin
                if (i_rd || i_wr) begin
                    nxt_state = ST_BURST;
                    nxt_beat  = burst_beats - 9'h001;
                end else if (i_pre) begin
                    nxt_state = ST_PRE;
                    nxt_cnt   = i_rp_cyc - {{(CNT_W-1){1'b0}}, 1'b1};
                end
            end
            ST_BURST: begin
                if (i_bst && i_burst_len == `SDC_BL_FULLPAGE) begin
                    nxt_state = ST_ACTV;
                end else if (i_rd || i_wr) begin
                    nxt_beat = burst_beats - 9'h001;
                end else if (i_pre) begin
                    nxt_state = ST_PRE;
                    nxt_cnt   = i_rp_cyc - {{(CNT_W-1){1'b0}}, 1'b1};
                end else if (beat_ff == 9'h000) begin
                    if (ap_ff && wr_ff) begin
                        nxt_state = ST_WRAP;
                        nxt_cnt   = i_dal_cyc - {{(CNT_W-1){1'b0}}, 1'b1};
                    end else if (ap_ff) begin
                        nxt_state = ST_PRE;
                        nxt_cnt   = i_rp_cyc - {{(CNT_W-1){1'b0}}, 1'b1};
                    end else begin
                        nxt_state = ST_ACTV;
                    end
                end
            end
            ST_WRAP: begin
                if (cnt_done)
                    nxt_state = ST_IDLE;
            end
            ST_PRE: begin
                if (cnt_done)
                    nxt_state = ST_IDLE;
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    always @(posedge i_clock) begin
        if (!i_rstn) begin
            state_ff <= ST_IDLE;
            cnt_ff   <= {CNT_W{1'b0}};
            ras_ff   <= {CNT_W{1'b0}};
            ap_ff    <= 1'b0;
            wr_ff    <= 1'b0;
            beat_ff  <= 9'h000;
        end else if (i_ena) begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
            beat_ff  <= nxt_beat;
            if (i_act && state_ff == ST_IDLE)
                ras_ff <= i_ras_cyc - {{(CNT_W-1){1'b0}}, 1'b1};
            else if (ras_ff != {CNT_W{1'b0}})
                ras_ff <= ras_ff - {{(CNT_W-1){1'b0}}, 1'b1};
            if (i_rd || i_wr) begin
                ap_ff <= i_ap;
                wr_ff <= i_wr;
            end
        end
    end

    assign o_state     = state_ff;
    assign o_ras_met   = (ras_ff == {CNT_W{1'b0}});
    assign o_row_ready = (state_ff == ST_ACTV) || (state_ff == ST_BURST);

endmodule // sdc_bank

// ---- sdc_cmd_ctrl.v ----
// command-acceptance logic of a two-bank synchronous dram
`timescale 1ns/1ns
`include "sdc_map.vh"

//****************************************************************
// How it works
// - sample all inputs on rising edge
// - decode command from four strobe pins
// - write recovery: nops, idle after interval
// - refresh state: nops, idle after precharge
// - mode load: nops, idle after delay
// - mode load captures address into register
// - refresh ignores address, internal row counter
// - self refresh ignores all but enable
// - burst stop only for full page
// - enable low, banks idle: power down
// - enable low plus refresh: self refresh
// - auto precharge closes bank at burst end
// - address bits 8 and 9 ignored except by mode load
// - self refresh exit waits row cycle
//****************************************************************

module sdc_cmd_ctrl #(
    parameter CNT_W   = 8,
    parameter DAL_CYC = `SDC_CYC(`SDC_T_DAL_NS),
    parameter RP_CYC  = `SDC_CYC(`SDC_T_RP_NS),
    parameter MCD_CYC = `SDC_CYC(`SDC_T_MCD_NS),
    parameter RCD_CYC = `SDC_CYC(`SDC_T_RCD_NS),
    parameter RRD_CYC = `SDC_CYC(`SDC_T_RRD_NS),
    parameter RAS_CYC = `SDC_CYC(`SDC_T_RAS_NS),
    parameter RC_CYC  = `SDC_CYC(`SDC_T_RC_NS),
    parameter WR_CYC  = `SDC_CYC(`SDC_T_WR_NS)
) (
    // clock and reset
    input  wire        i_clock,
    input  wire        i_rstn,
    // command pins
    input  wire        i_cke,
    input  wire        i_cs_n,
    input  wire        i_ras_n,
    input  wire        i_cas_n,
    input  wire        i_we_n,
    input  wire [11:0] i_addr,
    // state view
    output reg  [11:0] o_mode_reg,
    output reg  [3:0]  o_last_cmd,
    output reg         o_illegal,
    output reg  [2:0]  o_global_state,
    output reg  [2:0]  o_bank0_state,
    output reg  [2:0]  o_bank1_state,
    output reg  [10:0] o_refresh_row,
    output reg  [7:0]  o_column,
    output reg         o_powered_down,
    output reg         o_self_refresh
);

    //****************************************************************
    // global states
    //****************************************************************
    localparam GS_RUN   = 3'h0;
    localparam GS_REF   = 3'h1;
    localparam GS_MODE  = 3'h2;
    localparam GS_PDN   = 3'h3;
    localparam GS_SELF  = 3'h4;
    localparam GS_SXIT  = 3'h5;

    localparam BK_IDLE  = 3'h0;
    localparam BK_OPEN  = 3'h1;
    localparam BK_ACTV  = 3'h2;
    localparam BK_BURST = 3'h3;
    localparam BK_WRAP  = 3'h4;

    reg  [16:0] pin_s1_ff;
    reg  [16:0] pin_s2_ff;
    always @(posedge i_clock) begin
        if (!i_rstn) begin
            pin_s1_ff <= {4'hf, 1'b1, 12'h000};
            pin_s2_ff <= {4'hf, 1'b1, 12'h000};
        end else begin
            pin_s1_ff <= {i_cs_n, i_ras_n, i_cas_n, i_we_n, i_cke, i_addr};
            pin_s2_ff <= pin_s1_ff;
        end
    end

    wire        cs_n  = pin_s2_ff[16];
    wire [2:0]  code  = pin_s2_ff[15:13];
    wire        cke   = pin_s2_ff[12];
    wire [11:0] addr  = pin_s2_ff[11:0];
    wire        bank  = addr[`SDC_BANK_BIT];
    wire        ap    = addr[`SDC_AP_BIT];

    reg  [3:0]  cmd;
    always @* begin
        cmd = `SDC_CMD_DESELECT_CMD;
        if (!cs_n) begin
            case (code)
                `SDC_CODE_NOP:   cmd = `SDC_CMD_NOP;
                `SDC_CODE_BST:   cmd = `SDC_CMD_BST;
                `SDC_CODE_READ:  cmd = `SDC_CMD_READ;
                `SDC_CODE_WRITE: cmd = `SDC_CMD_WRITE;
                `SDC_CODE_ACT:   cmd = `SDC_CMD_ACT;
                `SDC_CODE_PRE:   cmd = `SDC_CMD_PRE;
                `SDC_CODE_REF:   cmd = `SDC_CMD_REF;
                default:         cmd = `SDC_CMD_MODE;
            endcase
        end
    end

    //****************************************************************
    // acceptance
    //****************************************************************
    reg  [2:0]       gstate_ff;
    reg  [2:0]       nxt_gstate;
    reg  [CNT_W-1:0] gcnt_ff;
    reg  [CNT_W-1:0] nxt_gcnt;
    reg  [CNT_W-1:0] rrd_ff;
    wire [2:0]       bk_state [0:1];
    wire [1:0]       bk_ras_met;
    wire [1:0]       bk_ready;
    wire             both_idle = (bk_state[0] == BK_IDLE) && (bk_state[1] == BK_IDLE);
    wire             gcnt_done = (gcnt_ff == {CNT_W{1'b0}});
    wire             run       = (gstate_ff == GS_RUN);
    wire             is_col    = (cmd == `SDC_CMD_READ) || (cmd == `SDC_CMD_WRITE);
    wire             pre_all   = ap && (cmd == `SDC_CMD_PRE);

    // legality of column, activate and precharge per addressed bank
    // activate needs idle bank
    wire ok_act = (bk_state[bank] == BK_IDLE) && (rrd_ff == {CNT_W{1'b0}});
    wire ok_col = bk_ready[bank];
    wire ok_pre = pre_all ? (bk_ras_met == 2'h3) : bk_ras_met[bank];
    wire [1:0] pre_hit = pre_all ? 2'h3 : (bank ? 2'h2 : 2'h1);

    reg  accept;
    reg  bad;
    always @* begin
        nxt_gstate = gstate_ff;
        nxt_gcnt   = gcnt_done ? gcnt_ff : gcnt_ff - {{(CNT_W-1){1'b0}}, 1'b1};
        accept     = 1'b0;
        bad        = 1'b0;
        case (gstate_ff)
            GS_RUN: begin
                if (!cke && both_idle && cmd != `SDC_CMD_REF) begin
                    nxt_gstate = GS_PDN;
                end else if (!cke && both_idle) begin
                    nxt_gstate = GS_SELF;
                end else begin
                    case (cmd)
                        `SDC_CMD_DESELECT_CMD, `SDC_CMD_NOP, `SDC_CMD_BST: accept = cke;
                        `SDC_CMD_READ, `SDC_CMD_WRITE: begin
                            accept = ok_col;
                            bad    = !ok_col;
                        end
                        `SDC_CMD_ACT: begin
                            accept = ok_act;
                            bad    = !ok_act;
                        end
                        `SDC_CMD_PRE: begin
                            accept = ok_pre;
                            bad    = !ok_pre;
                        end
                        `SDC_CMD_REF: begin
                            bad = !both_idle;
                            if (both_idle) begin
                                nxt_gstate = GS_REF;
                                nxt_gcnt   = RP_CYC[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1};
                            end
                        end
                        default: begin
                            bad = !both_idle;
                            if (both_idle) begin
                                nxt_gstate = GS_MODE;
                                nxt_gcnt   = MCD_CYC[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1};
                            end
                        end
                    endcase
                end
            end
            GS_REF, GS_MODE, GS_SXIT: begin
                bad = (cmd != `SDC_CMD_DESELECT_CMD) && (cmd != `SDC_CMD_NOP) &&
                      !(cmd == `SDC_CMD_BST && gstate_ff != GS_SXIT);
                if (gcnt_done)
                    nxt_gstate = GS_RUN;
            end
            GS_PDN: begin
                if (cke)
                    nxt_gstate = GS_RUN;
            end
            GS_SELF: begin
                if (cke) begin
                    nxt_gstate = GS_SXIT;
                    nxt_gcnt   = RC_CYC[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1};
                end
            end
            default: nxt_gstate = GS_RUN;
        endcase
    end

    wire bank_ena = run && cke;
    wire do_act   = accept && cmd == `SDC_CMD_ACT;
    wire do_rd    = accept && cmd == `SDC_CMD_READ;
    wire do_wr    = accept && cmd == `SDC_CMD_WRITE;
    wire do_pre   = accept && cmd == `SDC_CMD_PRE;
    wire do_bst   = accept && cmd == `SDC_CMD_BST;

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_bank
            sdc_bank #(
                .CNT_W (CNT_W)
            ) u_bank (
                .i_clock     (i_clock),
                .i_rstn      (i_rstn),
                .i_act       (do_act && bank == g),
                .i_rd        (do_rd && bank == g),
                .i_wr        (do_wr && bank == g),
                .i_ap        (ap),
                .i_pre       (do_pre && pre_hit[g]),
                .i_bst       (do_bst),
                .i_burst_len (o_mode_reg[`SDC_BL_LSB+2:`SDC_BL_LSB]),
                .i_ena       (bank_ena),
                .i_rcd_cyc   (RCD_CYC[CNT_W-1:0]),
                .i_rp_cyc    (RP_CYC[CNT_W-1:0]),
                .i_dal_cyc   (DAL_CYC[CNT_W-1:0]),
                .i_ras_cyc   (RAS_CYC[CNT_W-1:0]),
                .i_wr_cyc    (WR_CYC[CNT_W-1:0]),
                .o_state     (bk_state[g]),
                .o_ras_met   (bk_ras_met[g]),
                .o_row_ready (bk_ready[g])
            );
        end
    endgenerate

    always @(posedge i_clock) begin
        if (!i_rstn) begin
            gstate_ff      <= GS_RUN;
            gcnt_ff        <= {CNT_W{1'b0}};
            rrd_ff         <= {CNT_W{1'b0}};
            o_mode_reg     <= `SDC_MODE_RESET;
            o_last_cmd     <= `SDC_CMD_DESELECT_CMD;
            o_illegal      <= 1'b0;
            o_global_state <= GS_RUN;
            o_bank0_state  <= BK_IDLE;
            o_bank1_state  <= BK_IDLE;
            o_refresh_row  <= 11'h000;
            o_column       <= 8'h00;
            o_powered_down <= 1'b0;
            o_self_refresh <= 1'b0;
        end else begin
            gstate_ff      <= nxt_gstate;
            gcnt_ff        <= nxt_gcnt;
            o_global_state <= nxt_gstate;
            o_bank0_state  <= bk_state[0];
            o_bank1_state  <= bk_state[1];
            o_powered_down <= (nxt_gstate == GS_PDN);
            o_self_refresh <= (nxt_gstate == GS_SELF);
            o_illegal      <= bad && cke && (gstate_ff != GS_PDN) && (gstate_ff != GS_SELF);
            if (cke && gstate_ff != GS_PDN && gstate_ff != GS_SELF)
                o_last_cmd <= cmd;
            if (do_act)
                rrd_ff <= RRD_CYC[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1};
            else if (rrd_ff != {CNT_W{1'b0}})
                rrd_ff <= rrd_ff - {{(CNT_W-1){1'b0}}, 1'b1};
            if (run && cke && cmd == `SDC_CMD_MODE && both_idle)
                o_mode_reg <= addr;
            if (nxt_gstate == GS_REF && gstate_ff == GS_RUN)
                o_refresh_row <= o_refresh_row + 11'h001;
            // bits 8 and 9 dropped from column
            if (do_rd || do_wr)
                o_column <= addr[7:0];
        end
    end

endmodule // sdc_cmd_ctrl

// ---- sdc_ctl_model.sv ----
// controller model driving the sdram command pins
`timescale 1ns/1ns

module sdc_ctl_model (
    // clock
    input  wire        i_clock,
    // command pins
    output reg         o_cke,
    output reg         o_cs_n,
    output reg  [2:0]  o_code,
    output reg  [11:0] o_addr
);
    reg        pnd_v = 1'b0;
    reg [14:0] pnd   = 15'h0;
    reg        cke_v = 1'b1;

    initial begin
        o_cke  = 1'b1;
        o_cs_n = 1'b1;
        o_code = 3'h7;
        o_addr = 12'h0;
    end

    // pins change just after the edge
    always @(posedge i_clock) begin
        o_cke <= cke_v;
        if (pnd_v) begin
            o_cs_n           <= 1'b0;
            {o_code, o_addr} <= pnd;
            pnd_v <= 1'b0;
        end else begin
            // deselected lines toggle so no stale value looks valid
            o_cs_n <= 1'b1;
            o_code <= ~o_code;
            o_addr <= 12'($urandom);
        end
    end

    task issue(input logic [2:0] c, input logic [11:0] a);
        pnd   = {c, a};
        pnd_v = 1'b1;
        @(posedge i_clock);
        #1;
    endtask

    task set_cke(input logic v);
        cke_v = v;
    endtask
endmodule // sdc_ctl_model

// ---- sdc_cmd_ctrl_props.sv ----
// assertion checker for the sdram command ports
`timescale 1ns/1ns
`include "sdc_map.vh"

module sdc_cmd_chk #(
    parameter RP_CYC  = 2,
    parameter MCD_CYC = 1,
    parameter RCD_CYC = 2
) (
    // clock and reset
    input wire        i_clock,
    input wire        i_rstn,
    // command pins
    input wire        i_cke,
    input wire        i_cs_n,
    input wire        i_ras_n,
    input wire        i_cas_n,
    input wire        i_we_n,
    input wire [11:0] i_addr,
    // state view
    input wire [11:0] o_mode_reg,
    input wire [3:0]  o_last_cmd,
    input wire        o_illegal,
    input wire [2:0]  o_global_state,
    input wire [2:0]  o_bank0_state,
    input wire [2:0]  o_bank1_state,
    input wire [10:0] o_refresh_row,
    input wire        o_powered_down,
    input wire        o_self_refresh
);
    localparam int RP_H  = RP_CYC + 2;
    localparam int MCD_H = MCD_CYC + 2;
    localparam int RCD_D = RCD_CYC;
    wire [2:0] code = {i_ras_n, i_cas_n, i_we_n};

    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rstn);

    // run state, clock enabled, nothing in the pin pipeline
    sequence s_calm;
        i_cke && $past(i_cke) && $past(i_cke, 2) && $past(i_cs_n) && $past(i_cs_n, 2) &&
            $past(i_cs_n, 3) && o_global_state == 3'h0 && !o_powered_down && !o_self_refresh;
    endsequence
    property p_deselect_cmd;
        s_calm ##0 i_cs_n |-> ##3 o_last_cmd == `SDC_CMD_DESELECT_CMD;
    endproperty
    a_deselect_cmd: assert property (p_deselect_cmd) else $error("deselect decoded wrongly");
    property p_mode;
        s_calm ##0 (!i_cs_n && code == `SDC_CODE_MODE && o_bank0_state == 3'h0 && o_bank1_state == 3'h0)
            |-> ##3 (o_mode_reg == $past(i_addr, 3) && o_global_state == 3'h2);
    endproperty
    a_mode: assert property (p_mode) else $error("mode load not captured");
    property p_mode_exit;
        $rose(o_global_state == 3'h2) |-> ##[1:MCD_H] o_global_state == 3'h0;
    endproperty
    a_mode_exit: assert property (p_mode_exit) else $error("mode set state too long");
    property p_ref_exit;
        $rose(o_global_state == 3'h1) |-> ##[1:RP_H] o_global_state == 3'h0;
    endproperty
    a_ref_exit: assert property (p_ref_exit) else $error("refresh state too long");
    property p_row_step;
        o_refresh_row != $past(o_refresh_row) |-> o_refresh_row == $past(o_refresh_row) + 11'h1;
    endproperty
    a_row_step: assert property (p_row_step) else $error("refresh row jumped");
    property p_pd_quiet;
        o_powered_down && $past(o_powered_down, 3) |-> !o_illegal && $stable(o_mode_reg) && $stable(o_bank0_state);
    endproperty
    a_pd_quiet: assert property (p_pd_quiet) else $error("pins acted in power down");
    property p_sr_quiet;
        o_self_refresh && $past(o_self_refresh, 3) |-> !o_illegal && $stable(o_mode_reg) && $stable(o_bank0_state);
    endproperty
    a_sr_quiet: assert property (p_sr_quiet) else $error("pins acted in self refresh");
    property p_act_open;
        s_calm ##0 (!i_cs_n && code == `SDC_CODE_ACT && !i_addr[11] && o_bank0_state == 3'h0)
            |-> ##4 o_bank0_state == 3'h1 ##RCD_D o_bank0_state == 3'h2;
    endproperty
    a_act_open: assert property (p_act_open) else $error("activate timing wrong");
    property p_col_idle;
        s_calm ##0 (!i_cs_n && code == `SDC_CODE_READ && i_addr[11] && o_bank1_state == 3'h0) |-> ##3 o_illegal;
    endproperty
    a_col_idle: assert property (p_col_idle) else $error("read to idle bank taken");

    c_illegal: cover property (o_illegal);
    c_mode: cover property (o_global_state == 3'h2);
    c_pd: cover property (o_powered_down);
    c_sr: cover property (o_self_refresh);
endmodule // sdc_cmd_chk

bind sdc_cmd_ctrl sdc_cmd_chk #(
    .RP_CYC (RP_CYC),
    .MCD_CYC(MCD_CYC),
    .RCD_CYC(RCD_CYC)
) u_sdc_cmd_chk (
    .i_clock       (i_clock),
    .i_rstn        (i_rstn),
    .i_cke         (i_cke),
    .i_cs_n        (i_cs_n),
    .i_ras_n       (i_ras_n),
    .i_cas_n       (i_cas_n),
    .i_we_n        (i_we_n),
    .i_addr        (i_addr),
    .o_mode_reg    (o_mode_reg),
    .o_last_cmd    (o_last_cmd),
    .o_illegal     (o_illegal),
    .o_global_state(o_global_state),
    .o_bank0_state (o_bank0_state),
    .o_bank1_state (o_bank1_state),
    .o_refresh_row (o_refresh_row),
    .o_powered_down(o_powered_down),
    .o_self_refresh(o_self_refresh)
);

// ---- test_sdc_cmd_ctrl.sv ----
// self-checking bench for the sdram command block
`timescale 1ns/1ns
`include "sdc_map.vh"

module test_sdc_cmd_ctrl;
    typedef struct {int due; int kind; logic [11:0] val;} sdc_note_t;
    localparam int RP = 2, MCD = 1, RCD = 2, RAS = 3, DAL = 2, RC = 5, RRD = 2;
    localparam int K_CMD = 0, K_ILL = 1, K_MODE = 2, K_GST = 3, K_B0 = 4;
    localparam int K_B1 = 5, K_ROW = 6, K_PD = 7, K_SR = 8;
    reg          clock = 1'b0;
    reg          rst_n = 1'b0;
    wire         cke, cs_n, illegal, pdown, sref;
    wire [2:0]   code, gstate, b0_state, b1_state;
    wire [11:0]  addr, mode_reg;
    wire [3:0]   last_cmd;
    wire [10:0]  ref_row;
    wire [7:0]   column;
    int          fail_count = 0;
    int          num_checks = 0;
    int          cyc = 0;
    logic [11:0] a, m;
    sdc_note_t   q[$];

    sdc_ctl_model u_sdc_ctl_model (
        .i_clock(clock),
        .o_cke  (cke),
        .o_cs_n (cs_n),
        .o_code (code),
        .o_addr (addr)
    );
    sdc_cmd_ctrl #(.DAL_CYC(DAL), .RP_CYC(RP), .MCD_CYC(MCD), .RCD_CYC(RCD), .RAS_CYC(RAS), .RC_CYC(RC),
                   .RRD_CYC(RRD))
    u_sdc_cmd_ctrl (
        .i_clock       (clock),
        .i_rstn        (rst_n),
        .i_cke         (cke),
        .i_cs_n        (cs_n),
        .i_ras_n       (code[2]),
        .i_cas_n       (code[1]),
        .i_we_n        (code[0]),
        .i_addr        (addr),
        .o_mode_reg    (mode_reg),
        .o_last_cmd    (last_cmd),
        .o_illegal     (illegal),
        .o_global_state(gstate),
        .o_bank0_state (b0_state),
        .o_bank1_state (b1_state),
        .o_refresh_row (ref_row),
        .o_column      (column),
        .o_powered_down(pdown),
        .o_self_refresh(sref)
    );

    function automatic logic [11:0] got(input int k);
        case (k)
            K_CMD:   got = {8'h0, last_cmd};
            K_ILL:   got = {11'h0, illegal};
            K_MODE:  got = mode_reg;
            K_GST:   got = {9'h0, gstate};
            K_B0:    got = {9'h0, b0_state};
            K_B1:    got = {9'h0, b1_state};
            K_ROW:   got = {1'h0, ref_row};
            K_PD:    got = {11'h0, pdown};
            K_SR:    got = {11'h0, sref};
            default: got = {4'h0, column};
        endcase
    endfunction

    task note(input int k, input logic [11:0] v, input int d);
        q.push_back('{cyc + d, k, v});
    endtask
    task cmd(input logic [2:0] c, input logic [11:0] ad);
        u_sdc_ctl_model.issue(c, ad);
    endtask
    task gap(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task give_verdict;
        $display("checks %0d errors %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial forever #20 clock = ~clock;
    always @(posedge clock) cyc <= cyc + 1;

    // results settle well before the falling edge
    always @(negedge clock) begin
        for (int i = q.size() - 1; i >= 0; i--) begin
            if (q[i].due == cyc) begin
                num_checks++;
                if (got(q[i].kind) !== q[i].val) begin
                    fail_count++;
                    $display("ERROR t=%0t kind %0d got %h want %h", $time, q[i].kind, got(q[i].kind), q[i].val);
                end
                q.delete(i);
            end
        end
    end

    initial begin
        repeat (3000) @(posedge clock);
        fail_count++;
        give_verdict;
    end

    initial begin
        a = 12'($urandom(62996));
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        gap(1);
        for (int k = 0; k < 10; k++) note(k, 12'h0, 0);
        // burst length code 0, one beat
        m = 12'($urandom) & 12'hff8;
        cmd(`SDC_CODE_MODE, m);
        note(K_MODE, m, 3);
        note(K_CMD, 12'h8, 3);
        note(K_GST, 12'h2, 3);
        note(K_GST, 12'h0, 3 + MCD);
        gap(6);
        cmd(`SDC_CODE_REF, 12'($urandom));
        note(K_GST, 12'h1, 3);
        note(K_ROW, 12'h1, 3 + RP);
        note(K_MODE, m, 3 + RP);
        cmd(`SDC_CODE_ACT, 12'h000);
        note(K_ILL, 12'h1, 3);
        note(K_B0, 12'h0, 4);
        note(K_GST, 12'h0, 3 + RP);
        gap(6);
        cmd(`SDC_CODE_ACT, 12'h000);
        note(K_B0, 12'h1, 4);
        note(K_B0, 12'h2, 4 + RCD);
        cmd(`SDC_CODE_READ, 12'h000);
        note(K_ILL, 12'h1, 3);
        cmd(`SDC_CODE_PRE, 12'h000);
        note(K_ILL, 12'h1, 3);
        cmd(`SDC_CODE_ACT, 12'h000);
        note(K_ILL, 12'h1, 3);
        gap(3);
        cmd(`SDC_CODE_READ, 12'h800);
        note(K_ILL, 12'h1, 3);
        a = 12'($urandom) & 12'h3ff;
        cmd(`SDC_CODE_READ, a);
        note(K_CMD, 12'h3, 3);
        note(K_ILL, 12'h0, 3);
        note(9, {4'h0, a[7:0]}, 3);
        gap(4);
        cmd(`SDC_CODE_PRE, 12'h000);
        note(K_B0, 12'h5, 4);
        note(K_B0, 12'h0, 4 + RP);
        gap(6);
        cmd(`SDC_CODE_ACT, 12'h800);
        cmd(`SDC_CODE_ACT, 12'h000);
        note(K_ILL, 12'h1, 3);
        note(K_B0, 12'h0, 4);
        gap(RCD);
        cmd(`SDC_CODE_WRITE, 12'hc00);
        cmd(`SDC_CODE_REF, 12'h000);
        note(K_ILL, 12'h1, 3);
        cmd(`SDC_CODE_BST, 12'h000);
        note(K_CMD, 12'h2, 3);
        note(K_ILL, 12'h0, 3);
        note(K_B1, 12'h0, 6 + DAL + RP);
        gap(12);
        u_sdc_ctl_model.set_cke(1'b0);
        gap(1);
        note(K_PD, 12'h1, 3);
        note(K_GST, 12'h3, 3);
        cmd(`SDC_CODE_MODE, 12'($urandom));
        gap(4);
        note(K_MODE, m, 0);
        note(K_ILL, 12'h0, 0);
        u_sdc_ctl_model.set_cke(1'b1);
        gap(1);
        note(K_PD, 12'h0, 6);
        gap(8);
        u_sdc_ctl_model.set_cke(1'b0);
        cmd(`SDC_CODE_REF, 12'h000);
        note(K_SR, 12'h1, 3);
        note(K_GST, 12'h4, 3);
        cmd(`SDC_CODE_ACT, 12'h000);
        gap(4);
        note(K_B0, 12'h0, 0);
        note(K_ILL, 12'h0, 0);
        u_sdc_ctl_model.set_cke(1'b1);
        gap(1);
        note(K_SR, 12'h0, 5 + RC);
        note(K_GST, 12'h0, 5 + RC);
        gap(12);
        give_verdict;
    end
endmodule // test_sdc_cmd_ctrl
